// File: design/iocg_datapath.sv
// What this block does
// (RULE1) Input path offers delay and conditioning registers
// (RULE2) Input gearing ratios one, two, four, five
// (RULE3) Seven-to-one mode shares paired cell chain
// (RULE4) Shift, update, transfer register stages
// (RULE5) Capture pad bit on both fast edges
// (RULE6) Word boundary slips on core align request
// (RULE7) Parallel word registered on slow clock
// (RULE8) Per-pin input FIFO ahead of gearing
// (RULE9) FIFO written by strobe, read by fast clock
// (RULE10) Fast clock frequency equals strobe frequency
// (RULE11) One control unit makes group FIFO pointers
// (RULE12) Core drives align request to shift boundary
// (RULE13) Output registers core data, has delay cells
// (RULE14) Output serializing ratios one to seven-to-one
// (RULE15) Non-bottom output cells: single ratio only
// (RULE16) Seven-to-one output uses the adjacent pin pair
// (RULE17) Outgoing strobe made from strobe-write clock
// (RULE18) Outgoing data made from data-write clock
// (RULE19) Single rate: enable through one flip-flop
// (RULE20) Double rate: two-bit enable, slow and fast
// (RULE21) Each block has its own reset input
// (RULE22) Data-write clock is ninety degree shifted copy
// (RULE23) Reset clears gearing, FIFO, tri-state to zero
`timescale 1ns/10ps
`default_nettype none

module iocg_datapath
    import iocg_pkg::*;
#(
    parameter bit BOTTOM_EDGE = 1'b1
)
(
    // System clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_rst,
    input wire logic out_rst,
    input wire logic tri_rst,
    // Clocks arriving from outside, sampled as levels
    input wire logic fast_edge_clock,
    input wire logic slow_clock,
    input wire logic read_strobe,
    input wire logic strobe_write_clock,
    input wire logic data_write_clock,
    // Pads
    input wire logic pad_in,
    input wire logic pad_in_pair,
    output logic pad_out,
    output logic pad_out_pair,
    output logic pad_oe_n,
    output logic strobe_out,
    // Core controls
    input wire iocg_gear_t gear_mode,
    input wire logic mem_read_mode,
    input wire logic mem_write_mode,
    input wire logic word_align_request,
    input wire logic [IOCG_TAP_SEL_W-1:0] in_delay_sel,
    input wire logic [IOCG_TAP_SEL_W-1:0] out_delay_sel,
    input wire iocg_tri_t tri_ctrl,
    // Core data
    input wire logic [IOCG_WORD_W-1:0] out_word,
    output logic [IOCG_WORD_W-1:0] in_word,
    output logic in_word_valid,
    output logic buffer_enable_out
);

    // Bits per slow clock period for a gearing mode
    function automatic logic [IOCG_CNT_W-1:0] word_bits(input iocg_gear_t g, input logic bottom);
        word_bits = 4'h2;
        if (bottom)
        begin
            unique case (g)
                IOCG_INPUT_GEAR_RATIO_ONE: word_bits = 4'h2;
                IOCG_INPUT_GEAR_RATIO_TWO: word_bits = 4'h4;
                IOCG_INPUT_GEAR_RATIO_FOUR: word_bits = 4'h8;
                IOCG_INPUT_GEAR_RATIO_FIVE: word_bits = 4'hA;
                IOCG_INPUT_GEAR_SEVEN_TO_ONE: word_bits = 4'h7;
                default: word_bits = 4'h2;
            endcase
        end
    endfunction

    // Block resets, each joined with the system reset
    logic rst_in;
    logic rst_out;
    logic rst_tri;
    assign rst_in = sys_rst | in_rst; // RULE21
    assign rst_out = sys_rst | out_rst; // RULE21
    assign rst_tri = sys_rst | tri_rst; // RULE21

    // Two-stage synchronisers; the first stage feeds only the second
    logic [IOCG_S_N-1:0] sync1;
    logic [IOCG_S_N-1:0] sync2;
    logic [IOCG_S_N-1:0] sync_prev;
    logic [IOCG_S_N-1:0] outside;
    assign outside = {pad_in_pair, pad_in, data_write_clock, strobe_write_clock,
                      read_strobe, slow_clock, fast_edge_clock};

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync_prev <= '0;
        end
        else
        begin
            sync1 <= outside;
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    // Edge detectors on the synchronised clocks
    logic [IOCG_S_N-1:0] rise;
    logic [IOCG_S_N-1:0] fall;
    logic fast_edge;
    logic slow_rise;
    logic strobe_edge;
    logic dwck_edge;
    assign rise = sync2 & ~sync_prev;
    assign fall = ~sync2 & sync_prev;
    assign fast_edge = rise[IOCG_S_FAST] | fall[IOCG_S_FAST]; // RULE5
    assign slow_rise = rise[IOCG_S_SLOW];
    assign strobe_edge = rise[IOCG_S_RSTB] | fall[IOCG_S_RSTB];
    // Both edges of the quarter-period shifted clock land mid-bit of the strobe
    assign dwck_edge = rise[IOCG_S_DWCK] | fall[IOCG_S_DWCK]; // RULE22

    // Input delay line; the tap count trades range for latency
    logic [IOCG_TAPS-1:0] in_taps;
    logic in_delayed;
    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            in_taps <= '0;
        end
        else
        begin
            in_taps <= {in_taps[IOCG_TAPS-2:0], sync2[IOCG_S_PAD]}; // RULE1
        end
    end
    assign in_delayed = in_taps[in_delay_sel]; // RULE1

    // Group FIFO control: one pointer pair serves every cell of the group
    iocg_ptr_t ptrs;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_wr;
    logic fifo_rd;
    assign fifo_full = (ptrs.wr_ptr - ptrs.rd_ptr) == 4'(IOCG_FIFO_DEPTH);
    assign fifo_empty = ptrs.wr_ptr == ptrs.rd_ptr;
    assign fifo_wr = mem_read_mode & strobe_edge & ~fifo_full; // RULE9
    assign fifo_rd = mem_read_mode & fast_edge & ~fifo_empty; // RULE9

    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            ptrs <= {IOCG_PTR_RST, IOCG_PTR_RST}; // RULE23
        end
        else
        begin
            // A write on a full FIFO is dropped rather than overwrite unread data
            if (fifo_wr)
            begin
                ptrs.wr_ptr <= ptrs.wr_ptr + 4'h1; // RULE11
            end
            if (fifo_rd)
            begin
                ptrs.rd_ptr <= ptrs.rd_ptr + 4'h1; // RULE11
            end
        end
    end

    // Per-pin FIFO storage, written on strobe edges, read on fast edges
    logic [IOCG_FIFO_DEPTH-1:0] fifo_mem;
    logic fifo_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            fifo_mem <= '0; // RULE23
            fifo_q <= 1'b0;
        end
        else
        begin
            if (fifo_wr)
            begin
                fifo_mem[ptrs.wr_ptr[IOCG_PTR_W-2:0]] <= in_delayed; // RULE8
            end
            if (fifo_rd)
            begin
                fifo_q <= fifo_mem[ptrs.rd_ptr[IOCG_PTR_W-2:0]]; // RULE9
            end
        end
    end

    // Gearing source: FIFO for memory reads, pair chain for seven-to-one
    logic src_bit;
    logic [IOCG_CNT_W-1:0] in_bits;
    assign src_bit = mem_read_mode ? fifo_q : // RULE8
                     (gear_mode == IOCG_INPUT_GEAR_SEVEN_TO_ONE) ? sync2[IOCG_S_PAIR] : in_delayed; // RULE3
    assign in_bits = word_bits(gear_mode, BOTTOM_EDGE); // RULE2

    // Align request is held until the next fast edge consumes it
    logic align_prev;
    logic align_pend;
    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            align_prev <= 1'b0;
            align_pend <= 1'b0;
        end
        else
        begin
            align_prev <= word_align_request;
            // A new request in the consuming cycle wins over the clear
            if (word_align_request & ~align_prev)
            begin
                align_pend <= 1'b1; // RULE6
            end
            else if (fast_edge)
            begin
                align_pend <= 1'b0;
            end
        end
    end

    // Shift and update stages
    logic [IOCG_CHAIN_W-1:0] shift_chain;
    logic [IOCG_CNT_W-1:0] bit_cnt;
    logic [IOCG_WORD_W-1:0] update_word;
    logic [IOCG_CHAIN_W-1:0] next_chain;
    assign next_chain = {shift_chain[IOCG_CHAIN_W-2:0], src_bit};

    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            shift_chain <= IOCG_CHAIN_RST; // RULE23
            bit_cnt <= IOCG_CNT_RST;
            update_word <= IOCG_WORD_RST;
        end
        else if (fast_edge)
        begin
            shift_chain <= next_chain; // RULE4 RULE5
            if (align_pend)
            begin
                // Holding the count slips the boundary by one bit
                bit_cnt <= bit_cnt; // RULE6
            end
            else if (bit_cnt >= in_bits - 4'h1)
            begin
                bit_cnt <= IOCG_CNT_RST;
                update_word <= next_chain[IOCG_WORD_W-1:0] & ~(10'h3FF << in_bits); // RULE4 RULE6
            end
            else
            begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // Transfer stage onto the slow clock
    always_ff @(posedge sys_clk)
    begin
        if (rst_in)
        begin
            in_word <= IOCG_WORD_RST; // RULE23
            in_word_valid <= 1'b0;
        end
        else
        begin
            in_word_valid <= slow_rise; // RULE7
            if (slow_rise)
            begin
                in_word <= update_word; // RULE4 RULE7
            end
        end
    end

    // Output serializer: load on slow clock, shift on fast or data-write clock
    logic [IOCG_WORD_W-1:0] out_shift;
    logic [IOCG_CNT_W-1:0] out_cnt;
    logic [IOCG_CNT_W-1:0] out_bits;
    logic out_step;
    // Cells off the bottom edge get single ratio through the same function
    assign out_bits = word_bits(gear_mode, BOTTOM_EDGE); // RULE14 RULE15
    assign out_step = mem_write_mode ? dwck_edge : fast_edge; // RULE18

    always_ff @(posedge sys_clk)
    begin
        if (rst_out)
        begin
            out_shift <= IOCG_WORD_RST; // RULE23
            out_cnt <= IOCG_CNT_RST;
        end
        else if (slow_rise)
        begin
            out_shift <= out_word; // RULE13
            out_cnt <= out_bits;
        end
        else if (out_step && out_cnt != IOCG_CNT_RST)
        begin
            out_shift <= out_shift >> 1; // RULE14
            out_cnt <= out_cnt - 4'h1;
        end
    end

    // Output delay cells and pad registers
    logic [IOCG_TAPS-1:0] out_taps;
    always_ff @(posedge sys_clk)
    begin
        if (rst_out)
        begin
            out_taps <= '0;
            pad_out <= 1'b0;
            pad_out_pair <= 1'b0;
            strobe_out <= 1'b0;
        end
        else
        begin
            out_taps <= {out_taps[IOCG_TAPS-2:0], out_shift[0]};
            pad_out <= out_taps[out_delay_sel]; // RULE13
            // Complement copy on the adjacent pin only in seven-to-one mode
            pad_out_pair <= (gear_mode == IOCG_INPUT_GEAR_SEVEN_TO_ONE) & ~out_taps[out_delay_sel]; // RULE16
            strobe_out <= mem_write_mode & sync2[IOCG_S_SWCK]; // RULE17
        end
    end

    // Tri-state registers; a high enable output means the pad floats
    logic [1:0] tri_hold;
    logic double_rate;
    assign double_rate = BOTTOM_EDGE & tri_ctrl.enable_double_rate_mode;

    always_ff @(posedge sys_clk)
    begin
        if (rst_tri)
        begin
            tri_hold <= 2'h0; // RULE23
            buffer_enable_out <= 1'b0;
        end
        else
        begin
            if (slow_rise)
            begin
                tri_hold <= tri_ctrl.double_rate_enable_in; // RULE20
            end
            if (double_rate)
            begin
                if (rise[IOCG_S_FAST])
                begin
                    buffer_enable_out <= tri_hold[0]; // RULE20
                end
                else if (fall[IOCG_S_FAST])
                begin
                    buffer_enable_out <= tri_hold[1]; // RULE20
                end
            end
            else if (slow_rise)
            begin
                buffer_enable_out <= tri_ctrl.single_rate_enable_in; // RULE19
            end
        end
    end
    assign pad_oe_n = buffer_enable_out;

    property p_fifo_bound;
        @(posedge sys_clk) disable iff (rst_in)
        (ptrs.wr_ptr - ptrs.rd_ptr) <= 4'(IOCG_FIFO_DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO pointers apart by more than depth"); // RULE11

    property p_transfer;
        @(posedge sys_clk) disable iff (rst_in)
        slow_rise |=> in_word_valid && in_word == $past(update_word);
    endproperty
    a_transfer: assert property (p_transfer) else $error("Word not transferred on slow edge"); // RULE7

    property p_sdr_enable;
        @(posedge sys_clk) disable iff (rst_tri)
        (slow_rise && !double_rate) |=> buffer_enable_out == $past(tri_ctrl.single_rate_enable_in);
    endproperty
    a_sdr_enable: assert property (p_sdr_enable) else $error("Single rate enable not registered"); // RULE19

    property p_ddr_enable;
        @(posedge sys_clk) disable iff (rst_tri)
        (double_rate && fall[IOCG_S_FAST]) |=> buffer_enable_out == $past(tri_hold[1]);
    endproperty
    a_ddr_enable: assert property (p_ddr_enable) else $error("Double rate enable wrong on fall"); // RULE20

    property p_reset_clear;
        @(posedge sys_clk)
        rst_in |=> in_word == IOCG_WORD_RST && bit_cnt == IOCG_CNT_RST && !in_word_valid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Input block not cleared by reset"); // RULE23

    property p_strobe_quiet;
        @(posedge sys_clk) disable iff (rst_out)
        !mem_write_mode |=> !strobe_out;
    endproperty
    a_strobe_quiet: assert property (p_strobe_quiet) else $error("Strobe driven outside write mode"); // RULE17

    property p_align_slip;
        @(posedge sys_clk) disable iff (rst_in)
        // A fresh request in the consuming cycle re-arms the slip, so it is left out here
        (align_pend && fast_edge && !(word_align_request && !align_prev)) |=> bit_cnt == $past(bit_cnt) && !align_pend;
    endproperty
    a_align_slip: assert property (p_align_slip) else $error("Align request did not slip a bit"); // RULE6

    property p_out_load;
        @(posedge sys_clk) disable iff (rst_out)
        slow_rise |=> out_shift == $past(out_word) ##4 pad_out == $past(out_taps[out_delay_sel]);
    endproperty
    a_out_load: assert property (p_out_load) else $error("Core word not loaded for output"); // RULE13

endmodule

`default_nettype wire

// File: pkg/iocg_pkg.sv
package iocg_pkg;

    // Widest assembled word: two cells share the double-rate chain
    localparam int IOCG_CHAIN_W = 14;
    // Deepest word the gearing delivers (ratio five, both edges)
    localparam int IOCG_WORD_W = 10;
    // Input FIFO depth and pointer width (pointers carry a wrap bit)
    localparam int IOCG_FIFO_DEPTH = 8;
    localparam int IOCG_PTR_W = 4;
    // Programmable delay line length and select width
    localparam int IOCG_TAPS = 4;
    localparam int IOCG_TAP_SEL_W = 2;
    // Bit counter width
    localparam int IOCG_CNT_W = 4;

    // Positions of the outside inputs in the synchroniser vector
    localparam int IOCG_S_FAST = 0;
    localparam int IOCG_S_SLOW = 1;
    localparam int IOCG_S_RSTB = 2;
    localparam int IOCG_S_SWCK = 3;
    localparam int IOCG_S_DWCK = 4;
    localparam int IOCG_S_PAD = 5;
    localparam int IOCG_S_PAIR = 6;
    localparam int IOCG_S_N = 7;

    // Reset values: every gearing, FIFO and tri-state register clears to zero
    localparam logic [IOCG_CHAIN_W-1:0] IOCG_CHAIN_RST = 14'h0000;
    localparam logic [IOCG_WORD_W-1:0] IOCG_WORD_RST = 10'h000;
    localparam logic [IOCG_CNT_W-1:0] IOCG_CNT_RST = 4'h0;
    localparam logic [IOCG_PTR_W-1:0] IOCG_PTR_RST = 4'h0;

    // Gearing mode, one-hot
    typedef enum logic [4:0] {
        IOCG_INPUT_GEAR_RATIO_ONE = 5'h01,
        IOCG_INPUT_GEAR_RATIO_TWO = 5'h02,
        IOCG_INPUT_GEAR_RATIO_FOUR = 5'h04,
        IOCG_INPUT_GEAR_RATIO_FIVE = 5'h08,
        IOCG_INPUT_GEAR_SEVEN_TO_ONE = 5'h10
    } iocg_gear_t;

    // Pointers handed from the group FIFO control to each cell
    typedef struct packed {
        logic [IOCG_PTR_W-1:0] wr_ptr;
        logic [IOCG_PTR_W-1:0] rd_ptr;
    } iocg_ptr_t;

    // Tri-state controls from the core
    typedef struct packed {
        logic single_rate_enable_in;
        logic [1:0] double_rate_enable_in;
        logic enable_double_rate_mode;
    } iocg_tri_t;

endpackage

// File: tb/io_cell_gearing_datapath_tb.sv
`timescale 1ns/10ps
`default_nettype none

module io_cell_gearing_datapath_tb
    import iocg_pkg::*;
;
    localparam iocg_gear_t MODES [5] = '{IOCG_INPUT_GEAR_RATIO_ONE, IOCG_INPUT_GEAR_RATIO_TWO,
        IOCG_INPUT_GEAR_RATIO_FOUR, IOCG_INPUT_GEAR_RATIO_FIVE, IOCG_INPUT_GEAR_SEVEN_TO_ONE};
    localparam int BITS [5] = '{2, 4, 8, 10, 7};
    logic sys_clk, sys_rst, in_rst, out_rst, tri_rst;
    logic fast_edge_clock, slow_clock, read_strobe, strobe_write_clock, data_write_clock;
    logic pad_in, pad_in_pair, pad_out, pad_out_pair, pad_oe_n, strobe_out;
    logic mem_read_mode, mem_write_mode, word_align_request, in_word_valid, buffer_enable_out;
    iocg_gear_t gear_mode;
    logic [IOCG_TAP_SEL_W-1:0] in_delay_sel, out_delay_sel;
    iocg_tri_t tri_ctrl;
    logic [IOCG_WORD_W-1:0] out_word, in_word, tx_word, prev, mask;
    logic [3:0] n_bits; // Word length of the current mode
    int error_cnt, num_checks, seed, m, pop, c_out, c_str, c_pair, c_oe, c_ph;
    logic [1:0] fe_hist; // Fast pin level at the last two samples

    // System clock, 40 ns
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    iocg_partner link (.n_bits(n_bits), .word(tx_word), .fast_edge_clock(fast_edge_clock),
        .slow_clock(slow_clock), .read_strobe(read_strobe), .strobe_write_clock(strobe_write_clock),
        .data_write_clock(data_write_clock), .pad_in(pad_in), .pad_in_pair(pad_in_pair));

    iocg_datapath dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_rst(in_rst), .out_rst(out_rst),
        .tri_rst(tri_rst), .fast_edge_clock(fast_edge_clock), .slow_clock(slow_clock),
        .read_strobe(read_strobe), .strobe_write_clock(strobe_write_clock),
        .data_write_clock(data_write_clock), .pad_in(pad_in), .pad_in_pair(pad_in_pair),
        .pad_out(pad_out), .pad_out_pair(pad_out_pair), .pad_oe_n(pad_oe_n), .strobe_out(strobe_out),
        .gear_mode(gear_mode), .mem_read_mode(mem_read_mode), .mem_write_mode(mem_write_mode),
        .word_align_request(word_align_request), .in_delay_sel(in_delay_sel),
        .out_delay_sel(out_delay_sel), .tri_ctrl(tri_ctrl), .out_word(out_word), .in_word(in_word),
        .in_word_valid(in_word_valid), .buffer_enable_out(buffer_enable_out));

    // Rotate an n-bit word left by k places
    function automatic logic [9:0] rotl(input logic [9:0] w, input int n, input int k);
        return ((w << k) | (w >> (n - k))) & ((10'h001 << n) - 10'h001);
    endfunction

    // Boundary is unknown, so any rotation is fine; after a slip only a one-step one
    function automatic logic [9:0] pick(input logic [9:0] w, input logic [9:0] got, input int n,
        input bit slip);
        logic [9:0] r;
        r = rotl(w, n, slip ? 1 : 0);
        for (int k = 0; k < n; k++)
            if (rotl(w, n, k) === got && (!slip || k == 1 || k == n - 1))
                r = got;
        return r;
    endfunction

    // Compare of words
    task automatic chk_word(input string nm, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Compare of single bits and range verdicts
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Wait for cnt word pulses; a lost pulse ends the run
    task automatic wait_valid(input int cnt);
        int t;
        repeat (cnt)
        begin
            t = 0;
            @(negedge sys_clk);
            while (in_word_valid !== 1'b1)
            begin
                t++;
                if (t > 400)
                begin
                    error_cnt++;
                    results();
                end
                @(negedge sys_clk);
            end
        end
    endtask

    // Count high cycles of pad_out, strobe_out and the enable, pair mismatches and enable phase hits over a window
    task automatic count(input int cyc);
        c_out = 0;
        c_str = 0;
        c_pair = 0;
        c_oe = 0;
        c_ph = 0;
        fe_hist = 2'h0;
        repeat (cyc)
        begin
            @(negedge sys_clk);
            c_out += (pad_out === 1'b1);
            c_str += (strobe_out === 1'b1);
            c_oe += (buffer_enable_out === 1'b1);
            c_pair += (pad_out_pair !== ((m == 4) ? ~pad_out : 1'b0));
            // Enable trails the fast pin by two samples: bit0 after a rise, bit1 after a fall
            c_ph += (buffer_enable_out === tri_ctrl.double_rate_enable_in[!fe_hist[1]]);
            fe_hist = {fe_hist[0], fast_edge_clock};
        end
    endtask

    // Watchdog against a hang anywhere
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        results();
    end

    // Main sequence
    initial
    begin
        seed = 32'h2f35c9ff;
        error_cnt = 0;
        num_checks = 0;
        {sys_rst, in_rst, out_rst, tri_rst} = 4'h8;
        {mem_read_mode, mem_write_mode, word_align_request} = 3'h0;
        in_delay_sel = 2'h0;
        out_delay_sel = 2'h0;
        tri_ctrl = '0;
        out_word = 10'h000;
        gear_mode = IOCG_INPUT_GEAR_RATIO_ONE;
        n_bits = 4'h2;
        tx_word = 10'h001;
        m = 0;
        repeat (2) @(negedge sys_clk);
        chk_word("in_word at reset", 10'h000, in_word);
        chk_bit("buffer_enable_out at reset", 1'b0, buffer_enable_out);
        chk_bit("in_word_valid at reset", 1'b0, in_word_valid);
        sys_rst = 1'b0;
        // Every gearing ratio, with the FIFO path and write clocks in some of them
        for (m = 0; m < 5; m++)
        begin
            n_bits = 4'(BITS[m]);
            gear_mode = MODES[m];
            mask = (10'h001 << n_bits) - 10'h001;
            tx_word = (m == 0) ? 10'h001 : 10'($random(seed)) & mask;
            out_word = 10'($random(seed)) & mask;
            pop = $countones(out_word);
            in_delay_sel = 2'($random(seed));
            out_delay_sel = 2'($random(seed));
            mem_read_mode = (m == 1 || m == 3);
            mem_write_mode = (m == 2);
            wait_valid(6);
            chk_word("in_word", pick(tx_word, in_word, n_bits, 0), in_word);
            prev = in_word;
            word_align_request = 1'b1;
            @(negedge sys_clk);
            word_align_request = 1'b0;
            wait_valid(3);
            chk_word("in_word after slip", pick(prev, in_word, n_bits, 1), in_word);
            count(16 * n_bits);
            chk_bit("pad_out ones", 1'b1, c_out >= 16 * pop - 8 && c_out <= 16 * pop + 8);
            chk_bit("pad_out_pair", 1'b1, c_pair == 0);
            chk_bit("strobe_out", 1'b1, mem_write_mode ? (c_str > 4 * n_bits && c_str < 12 * n_bits) : c_str == 0);
        end
        m = 4;
        // Single rate enable, both levels
        for (int k = 0; k < 2; k++)
        begin
            tri_ctrl = '{k[0], 2'b00, 1'b0};
            wait_valid(2);
            chk_bit("buffer_enable_out", k[0], buffer_enable_out);
            chk_bit("pad_oe_n", k[0], pad_oe_n);
        end
        // Double rate: equal bits give a level, unequal bits toggle per fast edge
        tri_ctrl = '{1'b0, 2'b11, 1'b1};
        wait_valid(2);
        chk_bit("buffer_enable_out double", 1'b1, buffer_enable_out);
        tri_ctrl = '{1'b0, 2'b01, 1'b1};
        wait_valid(2);
        count(64);
        chk_bit("buffer_enable_out toggling", 1'b1, c_oe > 16 && c_oe < 48);
        // A swapped bit order would leave the enable out of phase with the fast pin
        chk_bit("buffer_enable_out phase", 1'b1, c_ph >= 48);
        // Block resets in mid-run clear every block's outputs
        {in_rst, out_rst, tri_rst} = 3'h7;
        repeat (3) @(negedge sys_clk);
        chk_word("in_word block reset", 10'h000, in_word);
        chk_bit("in_word_valid block reset", 1'b0, in_word_valid);
        chk_bit("pad_out block reset", 1'b0, pad_out);
        chk_bit("pad_out_pair block reset", 1'b0, pad_out_pair);
        chk_bit("strobe_out block reset", 1'b0, strobe_out);
        chk_bit("buffer_enable_out block reset", 1'b0, buffer_enable_out);
        {in_rst, out_rst, tri_rst} = 3'h0;
        wait_valid(6);
        chk_word("in_word after block reset", pick(tx_word, in_word, n_bits, 0), in_word);
        results();
    end
endmodule

`default_nettype wire

// File: tb/iocg_partner.sv
`timescale 1ns/10ps
`default_nettype none

module iocg_partner (
    // Frame shape chosen by the bench
    input wire logic [3:0] n_bits,
    input wire logic [9:0] word,
    // Link clocks and serial data
    output logic fast_edge_clock,
    output logic slow_clock,
    output logic read_strobe,
    output logic strobe_write_clock,
    output logic data_write_clock,
    output logic pad_in,
    output logic pad_in_pair
);
    int i; // Bit position in the word

    // Source repeats the word, one bit per fast edge, earliest bit highest
    initial
    begin
        fast_edge_clock = 1'b0;
        slow_clock = 1'b0;
        read_strobe = 1'b0;
        strobe_write_clock = 1'b0;
        data_write_clock = 1'b0;
        #7;
        forever
        begin
            for (i = 0; i < n_bits; i++)
            begin
                // Data changes half way between edges, so both sides see it centred
                pad_in = word[n_bits-1-i];
                pad_in_pair = word[n_bits-1-i];
                #80;
                fast_edge_clock = ~fast_edge_clock;
                // One slow period spans exactly one word
                if (i == 0)
                    slow_clock = 1'b1;
                else if (i == n_bits / 2)
                    slow_clock = 1'b0;
                #80;
            end
        end
    end

    // Strobes share the edge clock rate; the data write clock lags a quarter period
    always @(fast_edge_clock)
    begin
        read_strobe <= #40 fast_edge_clock;
        strobe_write_clock <= #1 fast_edge_clock;
        data_write_clock <= #80 fast_edge_clock;
    end
endmodule

`default_nettype wire
